// file: core/helper_out_defines.vh
`ifndef HELPER_OUT_DEFINES_VH
`define HELPER_OUT_DEFINES_VH
// Frame geometry
`define LINES_PER_FRAME 10'h271
`define FIRST_LINE 10'h001
// Reference lines
`define REF_LINE_A 10'h017
`define REF_LINE_B 10'h26F
// Core picture ranges
`define CORE_A_LO 10'h03C
`define CORE_A_HI 10'h112
`define CORE_B_LO 10'h174
`define CORE_B_HI 10'h24A
// Helper windows
`define HLP_A_LO 10'h018
`define HLP_A_HI 10'h03B
`define HLP_B_LO 10'h113
`define HLP_B_HI 10'h136
`define HLP_C_LO 10'h150
`define HLP_C_HI 10'h173
`define HLP_D_LO 10'h24B
`define HLP_D_HI 10'h26E
// Code levels
`define STD_BLACK 8'h10
`define CVBS_BLACK 8'h40
`define WSS_BLACK 8'h44
`define REF_BLACK 8'h80
`define HELPER_AMP 8'h6D
// Line class codes
`define CLS_STD 3'h0
`define CLS_CORE 3'h1
`define CLS_HELP 3'h2
`define CLS_REF 3'h3
// Lowpass: 2.5 MHz cutoff at 40 MHz, alpha = 2*pi*fc/fs about 3/8
`define LPF_SHIFT 4'h3
`define LPF_MUL 4'h3
// Mixer product is brought back to the sample scale, Q7
`define MIX_SHIFT 4'h7
// Gain is unsigned Q1.7, 0x80 is unity
`define GAIN_FRAC 4'h7
`endif

// file: core/out_buffer.v
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Two-entry skid buffer, stalls upstream when both entries hold data
module out_buffer #(
	parameter WIDTH = 11
) (
	input wire sys_clk_in,
	input wire rstn_in,
	input wire [WIDTH-1:0] in_data_in,
	input wire in_valid_in,
	output wire in_ready_out,
	output wire [WIDTH-1:0] out_data_out,
	output wire out_valid_out,
	input wire out_ready_in
);
	// Entry storage indexed by pointer
	reg [WIDTH-1:0] mem [0:1];
	reg wr_ptr;
	reg rd_ptr;
	reg [1:0] count;
	wire do_wr = in_valid_in && (count != 2'h2);
	wire do_rd = out_ready_in && (count != 2'h0);
	assign in_ready_out = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out = mem[rd_ptr];
	////////////////////////////////////////////////////////////////////////////////
	// Pointer and count update
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			mem[0] <= {WIDTH{1'b0}};
			mem[1] <= {WIDTH{1'b0}};
		end else begin
			// Write side
			if (do_wr) begin
				mem[wr_ptr] <= in_data_in;
				wr_ptr <= ~wr_ptr;
			end
			// Read side
			if (do_rd)
				rd_ptr <= ~rd_ptr;
			// Occupancy
			if (do_wr && !do_rd)
				count <= count + 2'h1;
			else if (do_rd && !do_wr)
				count <= count - 2'h1;
		end
	end
endmodule // out_buffer
`default_nettype wire

// file: core/palplus_helper_output.v
`timescale 1ns/1ps
`default_nettype none
`include "helper_out_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Helper preprocessing and luma port selection for PAL+ mode
module palplus_helper_output #(
	parameter COMP_DELAY = 4
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire rstn_in,
	// Mode level and sync pins
	input wire palplus_en_in,
	input wire vsync_in,
	input wire hsync_in,
	input wire wss_part_in,
	// Sample stream and gain
	input wire sample_valid_in,
	input wire [7:0] luma_in,
	input wire [7:0] cvbs_in,
	input wire signed [7:0] helper_adc_in,
	input wire signed [7:0] subcarrier_in,
	input wire [7:0] chroma_gain_loop_in,
	input wire hscale_en_in,
	// Luma port handshake
	output reg [7:0] luma_out,
	output reg luma_valid_out,
	input wire luma_ready_in,
	// Line status
	output reg [2:0] line_class_out,
	output reg comb_bypass_out,
	output reg helper_line_out,
	output reg sample_stall_out
);
	// Pin synchronisers for sync pulses
	reg vs_s1, vs_s2, vs_s3;
	reg hs_s1, hs_s2, hs_s3;
	// Line counter and class
	reg [9:0] line_cnt;
	reg [2:0] line_class;
	// Helper datapath
	reg signed [15:0] mix;
	reg signed [15:0] lpf;
	reg signed [15:0] scaled;
	reg signed [7:0] hdly [0:COMP_DELAY-1];
	reg [7:0] cdly [0:COMP_DELAY-1];
	reg [7:0] ldly [0:COMP_DELAY-1];
	reg hsc_phase;
	reg [7:0] next_luma;
	// Buffer side of the output path
	wire buf_ready;
	wire [10:0] buf_data;
	wire buf_valid;
	// Sync edges and sample acceptance
	wire vs_rise = vs_s2 && !vs_s3;
	wire hs_rise = hs_s2 && !hs_s3;
	wire advance = sample_valid_in && buf_ready;
	wire keep_sample = !hscale_en_in || !hsc_phase;
	wire [7:0] std_luma = (ldly[COMP_DELAY-1] < `STD_BLACK) ? `STD_BLACK : ldly[COMP_DELAY-1];
	// Loop index for the delay lines
	integer i;
	////////////////////////////////////////////////////////////////////////////////
	// Range test used for every line window
	function in_rng;
		input [9:0] v;
		input [9:0] lo;
		input [9:0] hi;
		begin
			in_rng = (v >= lo) && (v <= hi);
		end
	endfunction
	// Saturate a signed value to 8 bits
	function [7:0] sat8;
		input signed [15:0] v;
		begin
			if (v > 16'sh007F)
				sat8 = 8'h7F;
			else if (v < 16'shFF80)
				sat8 = 8'h80;
			else
				sat8 = v[7:0];
		end
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Sync synchronisers and line counter
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vs_s1 <= 1'b0;
			vs_s2 <= 1'b0;
			vs_s3 <= 1'b0;
			hs_s1 <= 1'b0;
			hs_s2 <= 1'b0;
			hs_s3 <= 1'b0;
			line_cnt <= `FIRST_LINE;
		end else begin
			vs_s1 <= vsync_in;
			vs_s2 <= vs_s1;
			vs_s3 <= vs_s2;
			hs_s1 <= hsync_in;
			hs_s2 <= hs_s1;
			hs_s3 <= hs_s2;
			if (vs_rise)
				line_cnt <= `FIRST_LINE;
			else if (hs_rise)
				line_cnt <= (line_cnt == `LINES_PER_FRAME) ? `FIRST_LINE : line_cnt + 10'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Line classification
	always @* begin
		if (!palplus_en_in)
			line_class = `CLS_STD;
		else if (line_cnt == `REF_LINE_A || line_cnt == `REF_LINE_B)
			line_class = `CLS_REF;
		else if (in_rng(line_cnt, `CORE_A_LO, `CORE_A_HI) ||
			in_rng(line_cnt, `CORE_B_LO, `CORE_B_HI))
			line_class = `CLS_CORE;
		else if (in_rng(line_cnt, `HLP_A_LO, `HLP_A_HI) ||
			in_rng(line_cnt, `HLP_B_LO, `HLP_B_HI) ||
			in_rng(line_cnt, `HLP_C_LO, `HLP_C_HI) ||
			in_rng(line_cnt, `HLP_D_LO, `HLP_D_HI))
			line_class = `CLS_HELP;
		else
			line_class = `CLS_STD;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Helper demodulation, filtering, gain and equal-length delay lines
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mix <= 16'sh0000;
			lpf <= 16'sh0000;
			scaled <= 16'sh0000;
			hsc_phase <= 1'b0;
			for (i = 0; i < COMP_DELAY; i = i + 1) begin
				hdly[i] <= 8'sh00;
				cdly[i] <= 8'h00;
				ldly[i] <= 8'h00;
			end
		end else if (advance) begin
			mix <= (helper_adc_in * subcarrier_in) >>> `MIX_SHIFT;
			lpf <= lpf + (((mix - lpf) * $signed({1'b0, `LPF_MUL})) >>> `LPF_SHIFT);
			scaled <= (lpf * $signed({1'b0, chroma_gain_loop_in})) >>> `GAIN_FRAC;
			hsc_phase <= hscale_en_in ? ~hsc_phase : 1'b0;
			// Equal-length delay lines, so helper trails composite by its three pipeline stages
			hdly[0] <= sat8(scaled);
			cdly[0] <= cvbs_in;
			ldly[0] <= luma_in;
			for (i = 1; i < COMP_DELAY; i = i + 1) begin
				hdly[i] <= hdly[i-1];
				cdly[i] <= cdly[i-1];
				ldly[i] <= ldly[i-1];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Output select with code levels per signal type
	always @* begin
		// Standard luma unless the line class says otherwise
		next_luma = std_luma;
		case (line_class)
			`CLS_CORE: next_luma = cdly[COMP_DELAY-1];
			`CLS_HELP: next_luma = hdly[COMP_DELAY-1];
			// WSS floored at black 68, else offset binary 128
			`CLS_REF: next_luma = wss_part_in ?
				(cdly[COMP_DELAY-1] < `WSS_BLACK ? `WSS_BLACK : cdly[COMP_DELAY-1]) :
				hdly[COMP_DELAY-1] + `REF_BLACK;
			default: next_luma = std_luma;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////////
	// Output buffer for downstream stalls; samples arriving while both entries are full are dropped
	out_buffer #(
		.WIDTH(11)
	) out_buffer_inst (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.in_data_in({line_class, next_luma}),
		.in_valid_in(sample_valid_in && keep_sample),
		.in_ready_out(buf_ready),
		.out_data_out(buf_data),
		.out_valid_out(buf_valid),
		// Pop exactly when the output register loads, so no word repeats
		.out_ready_in(luma_ready_in || !luma_valid_out)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			luma_out <= `STD_BLACK;
			luma_valid_out <= 1'b0;
			line_class_out <= `CLS_STD;
			comb_bypass_out <= 1'b0;
			helper_line_out <= 1'b0;
			sample_stall_out <= 1'b0;
		end else begin
			// Load a new word when the port is free or being emptied
			if (luma_ready_in || !luma_valid_out) begin
				luma_valid_out <= buf_valid;
				if (buf_valid) begin
					luma_out <= buf_data[7:0];
					line_class_out <= buf_data[10:8];
				end
			end
			comb_bypass_out <= (line_class == `CLS_HELP) || (line_class == `CLS_REF);
			helper_line_out <= (line_class == `CLS_HELP) || (line_class == `CLS_REF);
			sample_stall_out <= !buf_ready;
		end
	end
endmodule // palplus_helper_output
`default_nettype wire

// file: sim/helper_out_sva.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the luma port selection and output handshake
module helper_out_sva (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic palplus_en_in,
	input wire logic sample_valid_in,
	input wire logic [7:0] luma_out,
	input wire logic luma_valid_out,
	input wire logic luma_ready_in,
	input wire logic [2:0] line_class_out,
	input wire logic comb_bypass_out,
	input wire logic helper_line_out
);
	// Single domain, checks paused while reset is low
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	a_class_legal: assert property (line_class_out <= 3'h3)
		else $error("line class code out of range");
	a_bypass_helper: assert property (palplus_en_in[*3] ##0 helper_line_out
		|-> comb_bypass_out)
		else $error("comb filter active on a helper line");
	a_comb_off: assert property ((!palplus_en_in)[*3] |-> !comb_bypass_out)
		else $error("comb bypassed outside helper mode");
	a_bypass_mode: assert property ($rose(comb_bypass_out)
		|-> palplus_en_in || $past(palplus_en_in) || $past(palplus_en_in, 2))
		else $error("comb bypass rose without helper mode");
	a_hold_data: assert property (luma_valid_out && !luma_ready_in |=> $stable(luma_out))
		else $error("luma word changed while stalled");
	a_hold_valid: assert property (luma_valid_out && !luma_ready_in |=> luma_valid_out)
		else $error("luma valid dropped while stalled");
	a_std_floor: assert property (luma_valid_out && line_class_out == 3'h0
		|-> luma_out >= 8'h10)
		else $error("standard luma below black");
	a_idle_drain: assert property ((luma_ready_in && !sample_valid_in)[*8]
		|-> !luma_valid_out)
		else $error("output still valid with no input");
endmodule // helper_out_sva
bind palplus_helper_output helper_out_sva helper_out_sva_inst (.sys_clk_in, .rstn_in,
	.palplus_en_in, .sample_valid_in, .luma_out, .luma_valid_out, .luma_ready_in,
	.line_class_out, .comb_bypass_out, .helper_line_out);
`default_nettype wire

// file: sim/luma_sink.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Downstream helper processor: takes words, stalls three of four cycles when slow
module luma_sink (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic [7:0] luma_in,
	input wire logic luma_valid_in,
	input wire logic [2:0] class_in,
	output logic luma_ready_out,
	output logic [7:0] last_luma_out,
	output logic [2:0] last_class_out
);
	logic [1:0] phase; // Stall pattern position
	// Capture each accepted word, then pick next ready
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase <= 2'h0;
			luma_ready_out <= 1'b0;
			last_luma_out <= 8'h00;
			last_class_out <= 3'h0;
		end else begin
			if (luma_valid_in && luma_ready_out) begin
				last_luma_out <= luma_in;
				last_class_out <= class_in;
			end
			phase <= phase + 2'h1;
			luma_ready_out <= !slow_in || phase == 2'h3;
		end
	end
endmodule // luma_sink
`default_nettype wire

// file: sim/palplus_helper_output_bench.sv
`timescale 1ns/1ps
`default_nettype none
module palplus_helper_output_bench;
	logic sys_clk_in = 0, rstn_in = 0, palplus_en_in = 0, vsync_in = 0, hsync_in = 0, slow = 0;
	logic wss_part_in = 0, sample_valid_in = 0, hscale_en_in = 0, luma_valid_out, luma_ready_in;
	logic [7:0] luma_in = 8'h00, cvbs_in = 8'h00, gain = 8'h80, luma_out, last_luma;
	logic signed [7:0] helper_adc_in = 8'sh00, subcarrier_in = 8'sh00;
	logic comb_bypass_out, helper_line_out, sample_stall_out;
	logic [2:0] line_class_out, last_class;
	int miscompares = 0, checked = 0, line = 1;
	int taken = 0, stall_cycles = 0;
	// 40 MHz clock
	always #12.5 sys_clk_in = ~sys_clk_in;
	palplus_helper_output palplus_helper_output_inst (.sys_clk_in, .rstn_in, .palplus_en_in,
		.vsync_in, .hsync_in, .wss_part_in, .sample_valid_in, .luma_in, .cvbs_in,
		.helper_adc_in, .subcarrier_in, .chroma_gain_loop_in(gain), .hscale_en_in,
		.luma_out, .luma_valid_out, .luma_ready_in, .line_class_out, .comb_bypass_out,
		.helper_line_out, .sample_stall_out);
	luma_sink luma_sink_inst (.sys_clk_in, .rstn_in, .slow_in(slow), .luma_in(luma_out),
		.luma_valid_in(luma_valid_out), .class_in(line_class_out),
		.luma_ready_out(luma_ready_in), .last_luma_out(last_luma), .last_class_out(last_class));
	// Count words taken by the sink and cycles with upstream stalled
	always @(posedge sys_clk_in) begin
		if (luma_valid_out && luma_ready_in) taken <= taken + 1;
		if (sample_stall_out) stall_cycles <= stall_cycles + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Wait edges, then step just past the last one
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#2;
	endtask
	task automatic new_frame;
		vsync_in = 1;
		tick(2);
		vsync_in = 0;
		tick(6);
		line = 1;
	endtask
	task automatic next_line;
		hsync_in = 1;
		tick(2);
		hsync_in = 0;
		tick(6);
		line++;
	endtask
	// Helper windows plus the two reference lines
	function automatic logic is_help(input int n);
		return n == 23 || n == 623 || (n >= 24 && n <= 59) || (n >= 275 && n <= 310)
			|| (n >= 336 && n <= 371) || (n >= 587 && n <= 622);
	endfunction
	// Walk a whole frame checking line classification flags
	task automatic t_frame(input logic pal);
		palplus_en_in = pal;
		new_frame();
		repeat (625) begin
			check(8'(comb_bypass_out), 8'(pal & is_help(line)), "comb bypass");
			check(8'(helper_line_out), 8'(pal & is_help(line)), "helper line");
			next_line();
		end
		$display("frame test done, mode %0d", pal);
	endtask
	// Stream constant samples on one line, judge the last word taken
	task automatic t_data(input logic pal, input int ln, input logic [7:0] y, input logic [7:0] c,
		input logic [7:0] exp, input logic [2:0] cls, input logic s);
		int base_stall;
		palplus_en_in = pal;
		slow = s;
		luma_in = y;
		cvbs_in = c;
		new_frame();
		while (line < ln) next_line();
		base_stall = stall_cycles;
		sample_valid_in = 1;
		tick(48);
		sample_valid_in = 0;
		tick(16);
		check(last_luma, exp, "luma word");
		check(8'(last_class), 8'(cls), "line class");
		check(8'(stall_cycles != base_stall), 8'(s), "stall flag");
		$display("data test done on line %0d", ln);
	endtask
	// Horizontal scaling drops every second sample on all paths alike
	task automatic t_scale;
		int base_taken;
		slow = 0;
		luma_in = 8'h50;
		hscale_en_in = 1;
		tick(8);
		base_taken = taken;
		sample_valid_in = 1;
		tick(48);
		sample_valid_in = 0;
		tick(16);
		check(8'(taken - base_taken), 8'h18, "scaled word count");
		check(last_luma, 8'h50, "scaled luma");
		hscale_en_in = 0;
		$display("scale test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20);
		check(luma_out, 8'h10, "reset luma");
		rstn_in = 1;
		t_frame(1);
		t_frame(0);
		t_data(1, 60, 8'h30, 8'hA5, 8'hA5, 3'h1, 1);
		t_data(1, 586, 8'h30, 8'hA5, 8'hA5, 3'h1, 0);
		// Helper -64 mixed with 64 in Q7 is -32, half gain gives -16
		helper_adc_in = 8'shC0;
		subcarrier_in = 8'sh40;
		gain = 8'h40;
		t_data(1, 59, 8'h30, 8'hA5, 8'hF0, 3'h2, 0);
		// Black reference is offset binary: 128 - 16
		t_data(1, 23, 8'h30, 8'hA5, 8'h70, 3'h3, 0);
		wss_part_in = 1;
		t_data(1, 623, 8'h30, 8'h20, 8'h44, 3'h3, 0);
		wss_part_in = 0;
		t_data(0, 100, 8'h05, 8'hA5, 8'h10, 3'h0, 0);
		t_data(0, 60, 8'h90, 8'hA5, 8'h90, 3'h0, 1);
		t_scale();
		print_verdict();
	end
	// Hang guard, well past the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		miscompares++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule // palplus_helper_output_bench
`default_nettype wire
